//--- rtl/tcp_params.svh
// constants of the three-phase center-based pwm block
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

`define TCP_DATA_W        12
`define TCP_ADDR_W        4
`define TCP_TIME_W        7
`define TCP_NCH           3

`define TCP_ADDR_PERIOD   4'h0
`define TCP_ADDR_DUTY_A   4'h1
`define TCP_ADDR_DUTY_B   4'h2
`define TCP_ADDR_DUTY_C   4'h3
`define TCP_ADDR_DEADTIME 4'h4
`define TCP_ADDR_MINPULSE 4'h5
`define TCP_ADDR_STATUS   4'h6

`define TCP_CALC_LEAD     12'h004
`define TCP_OUTS_IDLE     6'h3f
`define TCP_SINCE_MAX     7'h7f

`endif

//--- rtl/tcp_pkg.sv
// state types of the pwm block
package tcp_pkg;
`include "tcp_params.svh"

    typedef struct packed {
        logic [`TCP_DATA_W-1:0] start;
        logic [`TCP_DATA_W-1:0] stop_at;
        logic                   del;
        logic [`TCP_DATA_W-1:0] s_start;
        logic [`TCP_DATA_W-1:0] s_stop;
        logic                   s_del;
        logic                   raw;
        logic [`TCP_TIME_W-1:0] since;
    } tcp_chan_t;

    typedef struct packed {
        logic [1:0]                       cs_n_s;
        logic [1:0]                       wr_n_s;
        logic [1:0]                       rd_n_s;
        logic [1:0]                       stop_s;
        logic [`TCP_ADDR_W-1:0]           a_s1;
        logic [`TCP_ADDR_W-1:0]           a_s2;
        logic [`TCP_DATA_W-1:0]           d_s1;
        logic [`TCP_DATA_W-1:0]           d_s2;
        logic                             wr_prev;
        logic [`TCP_ADDR_W-1:0]           wa;
        logic [`TCP_DATA_W-1:0]           wd;
        logic [`TCP_DATA_W-1:0]           cnt;
        logic [`TCP_DATA_W-1:0]           period;
        logic [`TCP_DATA_W-1:0]           period_act;
        logic [`TCP_NCH-1:0][`TCP_DATA_W-1:0] duty;
        logic [`TCP_NCH-1:0][`TCP_DATA_W-1:0] shadow;
        logic [`TCP_TIME_W-1:0]           deadtime;
        logic [`TCP_TIME_W-1:0]           thr;
        logic [`TCP_NCH-1:0]              wflags;
        logic                             pending;
        logic                             armed;
        logic                             loaded;
        logic                             sync;
        logic [5:0]                       outs_n;
        logic [`TCP_DATA_W-1:0]           rdata;
        logic                             oe;
    } tcp_state_t;
endpackage

//--- rtl/tcp_channel.sv
// one pwm phase: centered edge computation, pulse deletion and deadtime
`include "tcp_params.svh"
module tcp_channel (
    input  wire logic                   ref_clk,  // system clock
    input  wire logic                   rst_n,    // synchronous reset, low active
    input  wire logic [`TCP_DATA_W-1:0] cnt,      // period counter
    input  wire logic [`TCP_DATA_W-1:0] period,   // period for next cycle
    input  wire logic [`TCP_DATA_W-1:0] duty,     // latched on-time
    input  wire logic [`TCP_TIME_W-1:0] thr,      // minimum pulse width
    input  wire logic [`TCP_TIME_W-1:0] deadtime, // deadtime, lsb ignored
    input  wire logic                   calc,     // compute next edges
    input  wire logic                   apply,    // take computed edges
    input  wire logic                   run,      // a full set is loaded
    output logic                        main_act, // main switch on
    output logic                        comp_act  // complement switch on
);
    tcp_pkg::tcp_chan_t r;
    tcp_pkg::tcp_chan_t n;
    logic [`TCP_TIME_W-1:0] dt;
    logic [`TCP_DATA_W-1:0] gap;

    assign dt       = {deadtime[`TCP_TIME_W-1:1], 1'b0}; // RQ10
    assign main_act = r.raw && (r.since >= dt);         // RQ9
    assign comp_act = !r.raw && (r.since >= dt);        // RQ9

    always_comb begin
        n   = r;
        gap = period - duty;
        if (calc) begin
            n.s_del = ({5'h00, thr} > duty); // RQ11 RQ12
            if (duty >= period) begin
                n.s_start = '0;
                n.s_stop  = period;
            end else begin
                n.s_start = {1'b0, gap[`TCP_DATA_W-1:1]}; // RQ15
                n.s_stop  = {1'b0, gap[`TCP_DATA_W-1:1]} + duty; // RQ3 RQ15
            end
        end
        if (apply) begin
            n.start   = r.s_start;
            n.stop_at = r.s_stop;
            n.del     = r.s_del;
        end
        // edges land on whole clocks of the counter
        n.raw = run && !r.del && (cnt >= r.start) && (cnt < r.stop_at); // RQ1 RQ8 RQ11
        if (n.raw != r.raw) begin
            n.since = '0;
        end else if (r.since != `TCP_SINCE_MAX) begin
            n.since = r.since + 7'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // with a zero deadtime main may rise in the very clock the complement drops
    a_deadtime_on: assert property ($rose(main_act) && dt != '0 |-> r.since >= dt && !$past(comp_act)) // RQ9
        else $error("main turned on before deadtime elapsed");
    a_pair_exclusive: assert property (!(main_act && comp_act)) // RQ9
        else $error("both switches of a pair on");
    // the clock right after apply still shows the last count of the old period
    a_deleted_off: assert property (r.del && $past(r.del) |-> !main_act) // RQ11
        else $error("deleted pulse still drives main");
    a_center_sym: assert property (apply && !r.s_del && r.s_stop < period |=>
            (period - r.stop_at == r.start) || (period - r.stop_at == r.start + 12'h001)) // RQ15
        else $error("on-time not centered");
    c_deleted: cover property (apply && r.s_del);
endmodule

//--- rtl/tcp_pwm.sv
// three-phase center-based pwm timer with register port
// Operation
// [RQ1] three centered phases from three on-times, complemented with deadtime, 12-bit
// [RQ2] host loads period with clocks per switching period
// [RQ3] duty registers hold on-time in clocks; density is duty over period
// [RQ4] all six outputs are active low
// [RQ5] one-clock sync pulse at start of every period
// [RQ6] host writes duties at least four clocks before period start
// [RQ7] new duties take effect only after all three were rewritten
// [RQ8] output edges placed with one-clock granularity
// [RQ9] deadtime delay between complementary edges of each pair
// [RQ10] deadtime 7 bits, lsb forced zero, even counts 0 to 126
// [RQ11] pulse shorter than threshold: main fully off, complement fully on
// [RQ12] deletion threshold counts single clocks, 0 to 127
// [RQ13] shutdown high forces all six outputs high
// [RQ14] shutdown low resumes normal drive
// [RQ15] on-time centered about the middle of the period
// [RQ16] outputs inactive high until period and full duty set loaded
`include "tcp_params.svh"
module tcp_pwm (
    input  wire logic                   ref_clk,            // 25 MHz system clock
    input  wire logic                   rst_n,              // synchronous reset, low active
    input  wire logic [`TCP_ADDR_W-1:0] bus_addr,           // register address
    input  wire logic                   bus_cs_n,           // chip select, low active
    input  wire logic                   bus_wr_n,           // write strobe, low active
    input  wire logic                   bus_rd_n,           // read strobe, low active
    input  wire logic [`TCP_DATA_W-1:0] bus_data_in,        // data pins, input side
    output logic      [`TCP_DATA_W-1:0] bus_data_out,       // data pins, output side
    output logic                        bus_data_oe,        // data pins driven when high
    input  wire logic                   shutdown_in,        // external shutdown, high stops
    output logic                        period_start_pulse, // one clock per period
    output logic                        phase_a_out_n,      // phase a main, low on
    output logic                        phase_a_compl_out_n, // phase a complement, low on
    output logic                        phase_b_out_n,      // phase b main, low on
    output logic                        phase_b_compl_out_n, // phase b complement, low on
    output logic                        phase_c_out_n,      // phase c main, low on
    output logic                        phase_c_compl_out_n  // phase c complement, low on
);
    tcp_pkg::tcp_state_t r;
    tcp_pkg::tcp_state_t n;
    logic [`TCP_NCH-1:0] main_act;
    logic [`TCP_NCH-1:0] comp_act;
    logic                wr_act;
    logic                rd_act;
    logic                wr_done;
    logic                wrap;
    logic                calc;
    logic                apply;
    logic [5:0]          norm_n;
    logic [`TCP_NCH-1:0] wsel;

    // ============================================================
    // host port decode (strobes synchronised before use)
    // ============================================================
    assign wr_act  = !r.cs_n_s[1] && !r.wr_n_s[1];
    assign rd_act  = !r.cs_n_s[1] && !r.rd_n_s[1];
    assign wr_done = r.wr_prev && !wr_act;

    // ============================================================
    // period timing
    // ============================================================
    assign wrap  = (r.period_act == '0) || (r.cnt == r.period_act - 12'h001);
    assign calc  = r.pending && ((r.period_act < `TCP_CALC_LEAD) ? wrap :
                   (r.cnt == r.period_act - `TCP_CALC_LEAD)); // RQ6
    assign apply = wrap && r.armed;

    genvar gi;
    generate
        for (gi = 0; gi < `TCP_NCH; gi++) begin : g_ch
            assign wsel[gi] = wr_done && (r.wa == `TCP_ADDR_DUTY_A + 4'(gi));
            tcp_channel u_ch (
                .ref_clk  (ref_clk),
                .rst_n    (rst_n),
                .cnt      (r.cnt),
                .period   (r.period),
                .duty     (r.shadow[gi]),
                .thr      (r.thr),
                .deadtime (r.deadtime),
                .calc     (calc),
                .apply    (apply),
                .run      (r.loaded),
                .main_act (main_act[gi]),
                .comp_act (comp_act[gi])
            );
            assign norm_n[2*gi]   = !main_act[gi]; // RQ4
            assign norm_n[2*gi+1] = !comp_act[gi]; // RQ4
        end
    endgenerate

    always_comb begin
        n = r;
        // two-stage synchronisers
        n.cs_n_s = {r.cs_n_s[0], bus_cs_n};
        n.wr_n_s = {r.wr_n_s[0], bus_wr_n};
        n.rd_n_s = {r.rd_n_s[0], bus_rd_n};
        n.stop_s = {r.stop_s[0], shutdown_in};
        n.a_s1   = bus_addr;
        n.a_s2   = r.a_s1;
        n.d_s1   = bus_data_in;
        n.d_s2   = r.d_s1;
        n.wr_prev = wr_act;
        if (wr_act) begin
            n.wa = r.a_s2;
            n.wd = r.d_s2;
        end

        // ========================================================
        // register writes
        // ========================================================
        if (wr_done) begin
            case (r.wa)
                `TCP_ADDR_PERIOD:   n.period   = r.wd; // RQ2
                `TCP_ADDR_DEADTIME: n.deadtime = {r.wd[`TCP_TIME_W-1:1], 1'b0}; // RQ10
                `TCP_ADDR_MINPULSE: n.thr      = r.wd[`TCP_TIME_W-1:0]; // RQ12
                default: ;
            endcase
        end
        for (int i = 0; i < `TCP_NCH; i++) begin
            if (wsel[i]) begin
                n.duty[i] = r.wd; // RQ3
            end
        end

        // pending is cleared by calc, a completing write wins over the clear
        if (calc) begin
            n.pending = 1'b0;
            n.armed   = 1'b1;
        end
        n.wflags = r.wflags | wsel;
        if (&n.wflags) begin
            n.shadow  = n.duty; // RQ7
            n.pending = 1'b1;   // RQ7
            n.wflags  = '0;
        end

        // ========================================================
        // counter, sync and loading
        // ========================================================
        n.sync = 1'b0;
        if (wrap) begin
            n.cnt        = '0;
            n.period_act = r.period;
            n.sync       = (r.period != '0); // RQ5
        end else begin
            n.cnt = r.cnt + 12'h001;
        end
        if (apply) begin
            n.armed = calc;
            if (r.period != '0) begin
                n.loaded = 1'b1; // RQ16
            end
        end

        // ========================================================
        // output stage
        // ========================================================
        if (r.stop_s[1] || !r.loaded) begin
            n.outs_n = `TCP_OUTS_IDLE; // RQ13 RQ16
        end else begin
            n.outs_n = norm_n; // RQ14
        end

        // ========================================================
        // register reads
        // ========================================================
        n.oe = rd_act;
        case (r.a_s2)
            `TCP_ADDR_PERIOD:   n.rdata = r.period;
            `TCP_ADDR_DUTY_A:   n.rdata = r.duty[0];
            `TCP_ADDR_DUTY_B:   n.rdata = r.duty[1];
            `TCP_ADDR_DUTY_C:   n.rdata = r.duty[2];
            `TCP_ADDR_DEADTIME: n.rdata = {5'h00, r.deadtime};
            `TCP_ADDR_MINPULSE: n.rdata = {5'h00, r.thr};
            `TCP_ADDR_STATUS:   n.rdata = {6'h00, r.wflags, r.armed, r.pending, r.loaded};
            default:            n.rdata = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r        <= '0;
            r.cs_n_s <= 2'h3;
            r.wr_n_s <= 2'h3;
            r.rd_n_s <= 2'h3;
            r.outs_n <= `TCP_OUTS_IDLE;
        end else begin
            r <= n;
        end
    end

    assign bus_data_out        = r.rdata;
    assign bus_data_oe         = r.oe;
    assign period_start_pulse  = r.sync;
    assign phase_a_out_n       = r.outs_n[0];
    assign phase_a_compl_out_n = r.outs_n[1];
    assign phase_b_out_n       = r.outs_n[2];
    assign phase_b_compl_out_n = r.outs_n[3];
    assign phase_c_out_n       = r.outs_n[4];
    assign phase_c_compl_out_n = r.outs_n[5];

    // ============================================================
    // checks
    // ============================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_sync_one_clock: assert property (period_start_pulse && r.period_act > 12'h001
            |=> !period_start_pulse) // RQ5
        else $error("sync pulse longer than one clock");
    a_sync_at_start: assert property (period_start_pulse |-> r.cnt == '0) // RQ5
        else $error("sync pulse away from period start");
    a_stop_forces: assert property (r.stop_s[1] |=> r.outs_n == `TCP_OUTS_IDLE) // RQ13
        else $error("shutdown did not force outputs high");
    a_stop_resume: assert property (!r.stop_s[1] && r.loaded |=> r.outs_n == $past(norm_n)) // RQ14
        else $error("outputs not resumed after shutdown");
    a_idle_unloaded: assert property (!r.loaded |=> r.outs_n == `TCP_OUTS_IDLE) // RQ16
        else $error("outputs active before loading");
    a_all_three: assert property ($rose(r.pending) |-> $past(&(r.wflags | wsel))) // RQ7
        else $error("duties applied before all three written");
    a_pair_low: assert property (!(!phase_a_out_n && !phase_a_compl_out_n)
            && !(!phase_b_out_n && !phase_b_compl_out_n)) // RQ9
        else $error("complementary pair both low");
    a_apply_lead: assert property (calc && r.period_act >= `TCP_CALC_LEAD |-> ##3 wrap) // RQ6
        else $error("edges not computed four clocks ahead");
    c_stop: cover property ($rose(r.stop_s[1]) ##[1:200] $fell(r.stop_s[1]));
    c_load: cover property ($rose(r.loaded));
    c_period: cover property (period_start_pulse ##[2:200] period_start_pulse);
endmodule

//--- sim/tcp_gate_model.sv
// gate driver model of the three inverter legs that counts shoot-through cycles
module tcp_gate_model (
    input  wire logic ref_clk,   // system clock
    input  wire logic rst_n,     // synchronous reset, low active
    input  wire logic a_n,       // phase a main drive
    input  wire logic a_compl_n, // phase a complement drive
    input  wire logic b_n,       // phase b main drive
    input  wire logic b_compl_n, // phase b complement drive
    input  wire logic c_n,       // phase c main drive
    input  wire logic c_compl_n, // phase c complement drive
    output int        overlaps   // cycles with both switches of a leg on
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] both_on;

    // a low level turns the switch on
    assign both_on = {~c_n & ~c_compl_n, ~b_n & ~b_compl_n, ~a_n & ~a_compl_n};
    // a leg with both switches on would short the supply
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            overlaps <= 0;
        end else if (both_on !== 3'h0) begin
            overlaps <= overlaps + 1;
        end
    end
endmodule

//--- sim/three_phase_center_pwm_test.sv
// self-checking testbench of the three-phase pwm block
`define CHECK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module three_phase_center_pwm_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  bus_addr = 4'h0;
    logic        bus_cs_n = 1'b1;
    logic        bus_wr_n = 1'b1;
    logic        bus_rd_n = 1'b1;
    logic [11:0] bus_data_in = 12'h000;
    logic [11:0] bus_data_out;
    logic        bus_data_oe;
    logic        shutdown_in = 1'b0;
    logic        period_start_pulse;
    logic [5:0]  outs;
    int          overlaps;
    int          errors = 0;
    int          checks = 0;
    int          low [6];
    int          first [6];
    int          syncs;
    logic [11:0] rd;

    always #20 ref_clk = ~ref_clk;

    tcp_pwm DUT (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .bus_addr           (bus_addr),
        .bus_cs_n           (bus_cs_n),
        .bus_wr_n           (bus_wr_n),
        .bus_rd_n           (bus_rd_n),
        .bus_data_in        (bus_data_in),
        .bus_data_out       (bus_data_out),
        .bus_data_oe        (bus_data_oe),
        .shutdown_in        (shutdown_in),
        .period_start_pulse (period_start_pulse),
        .phase_a_out_n      (outs[0]),
        .phase_a_compl_out_n(outs[1]),
        .phase_b_out_n      (outs[2]),
        .phase_b_compl_out_n(outs[3]),
        .phase_c_out_n      (outs[4]),
        .phase_c_compl_out_n(outs[5])
    );

    tcp_gate_model gates (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .a_n      (outs[0]),
        .a_compl_n(outs[1]),
        .b_n      (outs[2]),
        .b_compl_n(outs[3]),
        .c_n      (outs[4]),
        .c_compl_n(outs[5]),
        .overlaps (overlaps)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // address and data settle before the strobe and stay until capture ends
    task automatic reg_wr(input logic [3:0] a, input logic [11:0] d);
        bus_addr = a;
        bus_data_in = d;
        tick(2);
        bus_cs_n = 1'b0;
        bus_wr_n = 1'b0;
        tick(4);
        bus_cs_n = 1'b1;
        bus_wr_n = 1'b1;
        tick(3);
        bus_addr = ~a;
        bus_data_in = ~d;
        tick(1);
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [11:0] e);
        int i;
        bus_addr = a;
        tick(2);
        bus_cs_n = 1'b0;
        bus_rd_n = 1'b0;
        for (i = 0; i < 10 && bus_data_oe !== 1'b1; i++) begin
            tick(1);
        end
        `CHECK("read enable", 1'b1, bus_data_oe)
        if (bus_data_oe !== 1'b1) finish_test();
        tick(3);
        `CHECK("read data", e, bus_data_out)
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_addr = ~a;
        tick(4);
    endtask

    task automatic wait_sync();
        int i;
        for (i = 0; i < 5000 && period_start_pulse !== 1'b1; i++) begin
            tick(1);
        end
        `CHECK("sync wait", 1'b1, period_start_pulse)
        if (period_start_pulse !== 1'b1) finish_test();
        tick(1);
    endtask

    // skips two periods so new duties are surely applied, then profiles one
    task automatic measure(input int p);
        int i;
        int k;
        repeat (3) wait_sync();
        syncs = 0;
        for (k = 0; k < 6; k++) begin
            low[k] = 0;
            first[k] = -1;
        end
        for (i = 0; i < p; i++) begin
            if (period_start_pulse === 1'b1) syncs++;
            for (k = 0; k < 6; k++) begin
                if (outs[k] === 1'b0) begin
                    low[k]++;
                    if (first[k] < 0) first[k] = i;
                end
            end
            tick(1);
        end
        `CHECK("sync count", 1, syncs)
    endtask

    task automatic expect_lows(input int am, ac, bm, bc, cm, cc);
        `CHECK("a main", am, low[0])
        `CHECK("a compl", ac, low[1])
        `CHECK("b main", bm, low[2])
        `CHECK("b compl", bc, low[3])
        `CHECK("c main", cm, low[4])
        `CHECK("c compl", cc, low[5])
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        tick(16);
        `CHECK("reset outputs", 6'h3f, outs)
        `CHECK("reset sync", 1'b0, period_start_pulse)
        `CHECK("reset oe", 1'b0, bus_data_oe)
        rst_n = 1'b1;
        tick(1);
        reg_rd(4'h0, 12'h000);
        reg_rd(4'h4, 12'h000);
        reg_wr(4'h9, 12'hfff);
        reg_rd(4'h9, 12'h000);
        reg_wr(4'h0, 12'h014);
        reg_wr(4'h4, 12'h003);
        reg_rd(4'h4, 12'h002);
        reg_wr(4'h5, 12'h07f);
        reg_rd(4'h5, 12'h07f);
        reg_wr(4'h5, 12'h008);
        reg_wr(4'h1, 12'h008);
        measure(20);
        expect_lows(0, 0, 0, 0, 0, 0);
        reg_rd(4'h6, 12'h008);
        reg_wr(4'h2, 12'h00c);
        reg_wr(4'h3, 12'h006);
        measure(20);
        // dt 2: main duty-2, complement period-duty-2, c below threshold
        expect_lows(6, 10, 10, 6, 0, 20);
        `CHECK("centering", 2, first[0] - first[2])
        reg_wr(4'h4, 12'h000);
        reg_wr(4'h5, 12'h000);
        reg_wr(4'h1, 12'h014);
        measure(20);
        expect_lows(8, 12, 12, 8, 0, 20);
        reg_wr(4'h2, 12'h001);
        reg_wr(4'h3, 12'h000);
        measure(20);
        expect_lows(20, 0, 1, 19, 0, 20);
        shutdown_in = 1'b1;
        tick(3);
        `CHECK("shutdown", 6'h3f, outs)
        measure(20);
        expect_lows(0, 0, 0, 0, 0, 0);
        shutdown_in = 1'b0;
        tick(3);
        `CHECK("resume", 1'b0, outs[0])
        measure(20);
        expect_lows(20, 0, 1, 19, 0, 20);
        `CHECK("shoot-through", 0, overlaps)
        reg_wr(4'h6, 12'hfff);
        reg_rd(4'h6, 12'h001);
        finish_test();
    end
endmodule
